/* File: core/rcip_pin_logic.sv */
// Reset pin, bus clock and interrupt pin logic of a small microcontroller.
`timescale 1ns/100ps
`include "rcip_regs.svh"

// Contract
// - A low driven onto the reset pin puts the controller into reset.
// - Watchdog or clock monitor failure pulls the reset pin low, open drain.
// - Pin high within two bus clocks after reset means internal, else external.
// - Bus clock is the oscillator clock divided by four.
// - Bus clock low phase is processing, high phase is data access.
// - Stop mode halts every generated clock, including the bus clock pin.
// - In single-chip modes the bus clock pin may be disabled; one variant cannot.
// - Software selects falling edge or low level for the maskable interrupt.
// - Every reset returns the maskable interrupt to low-level triggering.
// - Maskable interrupt requests may arrive asynchronously to the clock.
// - Reset sets the nonmaskable mask; once cleared, software cannot set it again.
// - The nonmaskable interrupt is recognised by its low level.
module rcip_pin_logic
  import rcip_pkg::*;
#(
  parameter bit ECLK_ALWAYS_ON = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic reset_pin_in,
  output logic      reset_pin_out,
  output logic      reset_pin_oe,
  input  wire logic watchdog_fail,
  input  wire logic clkmon_fail,
  output logic      system_reset,
  output logic      reset_internal,
  output logic      reset_done,
  input  wire logic stop_mode,
  input  wire logic single_chip_mode,
  input  wire logic eclk_disable,
  output logic      bus_clk_out,
  output logic      bus_clk_oe,
  output logic      cpu_access_phase,
  input  wire logic irq_pin_in,
  input  wire logic irq_mode_we,
  input  wire logic irq_mode_edge,
  input  wire logic irq_ack,
  output logic      irq_edge_mode,
  output logic      irq_request,
  input  wire logic nonmaskable_int_request,
  input  wire logic nmi_unmask,
  output logic      nmi_masked,
  output logic      nmi_request
);
  localparam int CW = `RCIP_CNT_W;
  // Sense and drive windows are held in bus clocks and converted to clk cycles.
  localparam logic [CW-1:0] SENSE_CLKS = CW'(`RCIP_SENSE_ECLKS * `RCIP_ECLK_DIV);
  localparam logic [CW-1:0] DRIVE_CLKS = CW'(`RCIP_DRIVE_ECLKS * `RCIP_ECLK_DIV);

  logic [2:0]      pins_s;
  logic            rst_pin_s;
  logic            irq_s;
  logic            nmi_s;
  logic            irq_s_d_r;
  logic            irq_fall;
  rcip_rst_state_t state_r;
  rcip_rst_state_t state_nxt;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   cnt_nxt;
  logic            fail;
  logic            sys_rst_r;
  logic            internal_r;
  logic            internal_nxt;
  logic            done_r;
  logic            done_nxt;
  logic [1:0]      phase_r;
  logic            eclk_en;
  logic            irq_mode_r;
  logic            irq_latch_r;
  logic            nmi_mask_r;
  logic            any_reset;

  rcip_sync #(
    .WIDTH   (3),
    .RST_VAL (`RCIP_PIN_IDLE)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({reset_pin_in, irq_pin_in, nonmaskable_int_request}),
    .dout (pins_s)
  );

  // Decoded synchronised levels and the failure request.
  assign rst_pin_s = pins_s[2];
  assign irq_s     = pins_s[1];
  assign nmi_s     = pins_s[0];
  assign fail      = watchdog_fail | clkmon_fail;
  assign any_reset = rst | sys_rst_r;

  // Reset sequencer: external hold, internal drive, then release sensing.
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    internal_nxt = internal_r;
    done_nxt     = 1'b0;
    case (state_r)
      RCIP_ST_IDLE: begin
        cnt_nxt = '0;
        if (fail) begin
          state_nxt = RCIP_ST_DRIVE;
        end else if (!rst_pin_s) begin
          state_nxt = RCIP_ST_EXT;
        end
      end
      RCIP_ST_EXT: begin
        if (rst_pin_s) begin
          state_nxt    = RCIP_ST_IDLE;
          internal_nxt = 1'b0;
          done_nxt     = 1'b1;
        end
      end
      RCIP_ST_DRIVE: begin
        if (cnt_r == DRIVE_CLKS - CW'(1)) begin
          state_nxt = RCIP_ST_SENSE;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      RCIP_ST_SENSE: begin
        if (rst_pin_s) begin
          state_nxt    = RCIP_ST_IDLE;
          internal_nxt = 1'b1;
          done_nxt     = 1'b1;
        end else if (cnt_r == SENSE_CLKS - CW'(1)) begin
          state_nxt = RCIP_ST_EXT;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        state_nxt = RCIP_ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= RCIP_ST_IDLE;
      cnt_r      <= '0;
      internal_r <= 1'b0;
      done_r     <= 1'b0;
      sys_rst_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      internal_r <= internal_nxt;
      done_r     <= done_nxt;
      sys_rst_r  <= (state_nxt != RCIP_ST_IDLE);
    end
  end

  // The pin is only ever pulled low, so an external pull-up sets its high level.
  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe   = state_r[2];
  assign system_reset   = sys_rst_r;
  assign reset_internal = internal_r;
  assign reset_done     = done_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 2'h0;
    end else if (!stop_mode) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Optional pin disable.
  // The pin is left floating, not low, when disabled, which removes all edges.
  assign bus_clk_out      = phase_r[1];
  assign cpu_access_phase = phase_r[1];
  assign eclk_en          = ECLK_ALWAYS_ON | ~(single_chip_mode & eclk_disable);
  assign bus_clk_oe       = eclk_en;

  // Falling edge detect on the second synchroniser stage only.
  assign irq_fall = irq_s_d_r & ~irq_s;

  always_ff @(posedge clk) begin
    if (any_reset) begin
      irq_mode_r <= `RCIP_IRQ_MODE_RST;
    end else if (irq_mode_we) begin
      irq_mode_r <= irq_mode_edge;
    end
  end

  always_ff @(posedge clk) begin
    if (any_reset) begin
      irq_s_d_r   <= 1'b1;
      irq_latch_r <= 1'b0;
    end else begin
      irq_s_d_r   <= irq_s;
      irq_latch_r <= (irq_mode_r & irq_fall) | (irq_latch_r & ~irq_ack);
    end
  end

  // Level mode follows line.
  // A held-low line simply keeps requesting, so no acknowledge is needed in level mode.
  assign irq_request   = irq_mode_r ? irq_latch_r : ~irq_s;
  assign irq_edge_mode = irq_mode_r;

  always_ff @(posedge clk) begin
    if (any_reset) begin
      nmi_mask_r <= `RCIP_NMI_MASK_RST;
    end else if (nmi_unmask) begin
      nmi_mask_r <= 1'b0;
    end
  end

  assign nmi_request = ~nmi_s & ~nmi_mask_r;
  assign nmi_masked  = nmi_mask_r;

  // Checks on the behaviour above.
  property p_ext_reset;
    @(posedge clk) disable iff (rst)
      (state_r == RCIP_ST_IDLE && !fail && !rst_pin_s) |=>
        system_reset ##1 (system_reset || reset_done);
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external reset not taken");

  property p_fail_drive;
    @(posedge clk) disable iff (rst)
      (state_r == RCIP_ST_IDLE && fail) |=> reset_pin_oe[*8];
  endproperty
  a_fail_drive: assert property (p_fail_drive) else $error("reset pin not driven on failure");

  property p_internal_class;
    @(posedge clk) disable iff (rst)
      (state_r == RCIP_ST_SENSE && rst_pin_s) |=> (reset_internal && reset_done);
  endproperty
  a_internal_class: assert property (p_internal_class) else $error("bad internal class");

  property p_external_class;
    @(posedge clk) disable iff (rst)
      (state_r == RCIP_ST_EXT && rst_pin_s) |=> (!reset_internal && reset_done);
  endproperty
  a_external_class: assert property (p_external_class) else $error("bad external class");

  property p_eclk_div;
    @(posedge clk) disable iff (rst)
      ($rose(bus_clk_out) && !stop_mode) ##1 (!stop_mode)[*3] |=> $rose(bus_clk_out);
  endproperty
  a_eclk_div: assert property (p_eclk_div) else $error("bus clock period not four");

  property p_stop_halt;
    @(posedge clk) disable iff (rst)
      stop_mode |=> $stable(bus_clk_out) && $stable(phase_r);
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("clock ran in stop mode");

  property p_eclk_disable;
    @(posedge clk) disable iff (rst)
      (single_chip_mode && eclk_disable) |-> (bus_clk_oe == ECLK_ALWAYS_ON);
  endproperty
  a_eclk_disable: assert property (p_eclk_disable) else $error("bus clock pin not disabled");

  property p_irq_edge;
    @(posedge clk) disable iff (rst)
      (irq_edge_mode && irq_fall && !sys_rst_r && !irq_mode_we) |=> irq_request;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("edge request lost");

  property p_irq_reset_level;
    @(posedge clk) disable iff (rst)
      system_reset |=> !irq_edge_mode && nmi_masked;
  endproperty
  a_irq_reset_level: assert property (p_irq_reset_level) else $error("reset left edge mode");

  property p_nmi_sticky;
    @(posedge clk) disable iff (rst)
      (!nmi_masked && !sys_rst_r) |=> !nmi_masked;
  endproperty
  a_nmi_sticky: assert property (p_nmi_sticky) else $error("mask set again by software");

  property p_nmi_level;
    @(posedge clk) disable iff (rst)
      (!nonmaskable_int_request ##2 !nmi_masked) |-> nmi_request;
  endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("low level not recognised");

  property p_sync_delay;
    @(posedge clk) disable iff (rst)
      $fell(nonmaskable_int_request) ##1 !nonmaskable_int_request |=> !nmi_s;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");

  c_internal: cover property (@(posedge clk) disable iff (rst) reset_done && reset_internal);
  c_external: cover property (@(posedge clk) disable iff (rst) reset_done && !reset_internal);
  c_irq_edge: cover property (@(posedge clk) disable iff (rst) irq_edge_mode && irq_request);
  c_nmi:      cover property (@(posedge clk) disable iff (rst) nmi_request);
endmodule // rcip_pin_logic

/* File: shared/rcip_regs.svh */
// Timing counts and reset values for the reset, clock and interrupt pin logic.
`ifndef RCIP_REGS_SVH
`define RCIP_REGS_SVH
`define RCIP_ECLK_DIV      4
`define RCIP_SENSE_ECLKS   2
`define RCIP_DRIVE_ECLKS   4
`define RCIP_CNT_W         8
`define RCIP_PIN_IDLE      3'h7
`define RCIP_IRQ_MODE_RST  1'h0
`define RCIP_NMI_MASK_RST  1'h1
`endif

/* File: shared/rcip_pkg.sv */
// Types shared by the reset, clock and interrupt pin logic.
package rcip_pkg;
  typedef enum logic [3:0] {
    RCIP_ST_IDLE  = 4'h1,
    RCIP_ST_EXT   = 4'h2,
    RCIP_ST_DRIVE = 4'h4,
    RCIP_ST_SENSE = 4'h8
  } rcip_rst_state_t;
endpackage

/* File: core/rcip_sync.sv */
// Two-stage synchroniser for a group of pin levels.
`timescale 1ns/100ps
module rcip_sync #(
  parameter int       WIDTH   = 3,
  parameter bit [2:0] RST_VAL = 3'h7
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second; pins idle high so reset loads ones.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL[WIDTH-1:0];
      dout   <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // rcip_sync

/* File: tb/rcip_far_side.sv */
// Model of the reset circuit and the wired-OR interrupt sources at the pins.
`timescale 1ns/100ps
module rcip_far_side (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reset_pin_out,
  input  wire logic       reset_pin_oe,
  input  wire logic       ext_hold,
  input  wire logic [1:0] irq_raise,
  input  wire logic       irq_ack,
  input  wire logic       nmi_hold,
  output logic            reset_pin_in,
  output logic            irq_pin_in,
  output logic            nmi_pin_in
);
  logic [1:0] pend_r;
  logic [1:0] pend_nxt;
  logic [1:0] lowest;

  // Each acknowledge retires one source only, so a second source keeps the line low.
  assign lowest   = pend_r[0] ? 2'h1 : {pend_r[1], 1'h0};
  assign pend_nxt = (pend_r | irq_raise) & ~(irq_ack ? lowest : 2'h0);

  // Sources hold until acknowledged.
  // Pending flags start clear so the shared line idles high from the first edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= 2'h0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Open drain lines.
  // Every party only pulls low; the pull-ups give a clean high when all let go.
  assign reset_pin_in = ~ext_hold & (reset_pin_oe ? reset_pin_out : 1'h1);
  assign irq_pin_in   = ~|pend_r;
  assign nmi_pin_in   = ~nmi_hold;
endmodule // rcip_far_side

/* File: tb/rcip_pin_logic_tb_top.sv */
// Self-checking testbench for the reset, bus clock and interrupt pin logic.
`timescale 1ns/100ps
module rcip_pin_logic_tb_top;
  logic       clk, rst, wd, cm, stp, sc, ed, we, edg, ack, unm, ext, nmh;
  logic [1:0] raise;
  logic       rpi, oe, sysr, rint, rdone, bclk, boe, cap, ipin, iem, ireq, npin, nmsk, nreq;
  logic       rpo, boe2;
  logic [7:0] got;
  logic       b;
  int         failures, check_count;

  rcip_pin_logic dut (.clk(clk), .rst(rst), .reset_pin_in(rpi), .reset_pin_out(rpo),
    .reset_pin_oe(oe), .watchdog_fail(wd), .clkmon_fail(cm), .system_reset(sysr),
    .reset_internal(rint), .reset_done(rdone), .stop_mode(stp), .single_chip_mode(sc),
    .eclk_disable(ed), .bus_clk_out(bclk), .bus_clk_oe(boe), .cpu_access_phase(cap),
    .irq_pin_in(ipin), .irq_mode_we(we), .irq_mode_edge(edg), .irq_ack(ack),
    .irq_edge_mode(iem), .irq_request(ireq), .nonmaskable_int_request(npin),
    .nmi_unmask(unm), .nmi_masked(nmsk), .nmi_request(nreq));

  // Variant whose bus clock pin cannot be disabled, run in parallel for the mode check.
  rcip_pin_logic #(.ECLK_ALWAYS_ON(1'b1)) dut_fixed (.clk(clk), .rst(rst),
    .reset_pin_in(rpi), .reset_pin_out(), .reset_pin_oe(), .watchdog_fail(wd),
    .clkmon_fail(cm), .system_reset(), .reset_internal(), .reset_done(), .stop_mode(stp),
    .single_chip_mode(sc), .eclk_disable(ed), .bus_clk_out(), .bus_clk_oe(boe2),
    .cpu_access_phase(), .irq_pin_in(ipin), .irq_mode_we(we), .irq_mode_edge(edg),
    .irq_ack(ack), .irq_edge_mode(), .irq_request(), .nonmaskable_int_request(npin),
    .nmi_unmask(unm), .nmi_masked(), .nmi_request());

  rcip_far_side far (.clk(clk), .rst(rst), .reset_pin_out(rpo), .reset_pin_oe(oe),
    .ext_hold(ext), .irq_raise(raise), .irq_ack(ack), .nmi_hold(nmh), .reset_pin_in(rpi),
    .irq_pin_in(ipin), .nmi_pin_in(npin));

  // Free-running oscillator clock of 4 ns.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task chk(input string name, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Inputs always move 1 ns after the rising edge.
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask

  // Bounded wait; a hung sequencer shows up as a missing done pulse.
  task wait_done;
    for (int i = 0; i < 60 && rdone !== 1'h1; i++) cyc(1);
    chk("reset_done", rdone, 1'h1);
  endtask

  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  initial begin
    #20000;
    failures++;
    test_done();
  end

  initial begin
    {wd, cm, stp, sc, ed, we, edg, ack, unm, ext, nmh} = '0;
    raise = 2'h0;
    rst = 1'h1;
    cyc(16);
    rst = 1'h0;
    cyc(3);
    chk("nmi_masked", nmsk, 1'h1);
    chk("irq_edge_mode", iem, 1'h0);
    chk("system_reset", sysr, 1'h0);
    $display("test reset state done");
    for (int i = 0; i < 8; i++) begin
      got[i] = bclk;
      chk("cpu_access_phase", cap, bclk);
      cyc(1);
    end
    for (int i = 0; i < 6; i++) chk("bus_clk_out", got[i+2], ~got[i]);
    stp = 1'h1;
    b = bclk;
    cyc(6);
    chk("bus_clk_out stopped", bclk, b);
    stp = 1'h0;
    for (int m = 0; m < 4; m++) begin
      {sc, ed} = m[1:0];
      cyc(1);
      chk("bus_clk_oe", boe, m != 3);
      chk("bus_clk_oe fixed variant", boe2, 1'h1);
    end
    {sc, ed} = 2'h0;
    $display("test bus clock done");
    nmh = 1'h1;
    cyc(4);
    chk("nmi_request masked", nreq, 1'h0);
    pulse(unm);
    cyc(3);
    chk("nmi_masked", nmsk, 1'h0);
    chk("nmi_request", nreq, 1'h1);
    nmh = 1'h0;
    cyc(4);
    chk("nmi_request idle", nreq, 1'h0);
    $display("test nonmaskable done");
    // Level triggering while two sources share the line.
    raise = 2'h3;
    cyc(1);
    raise = 2'h0;
    cyc(4);
    chk("irq_request level", ireq, 1'h1);
    pulse(ack);
    cyc(4);
    chk("irq_request second source", ireq, 1'h1);
    pulse(ack);
    cyc(4);
    chk("irq_request released", ireq, 1'h0);
    edg = 1'h1;
    pulse(we);
    chk("irq_edge_mode", iem, 1'h1);
    // Edge triggering with a single source only.
    raise = 2'h1;
    cyc(1);
    raise = 2'h0;
    cyc(5);
    chk("irq_request edge", ireq, 1'h1);
    pulse(ack);
    cyc(4);
    chk("irq_request edge cleared", ireq, 1'h0);
    $display("test maskable done");
    pulse(wd);
    chk("reset_pin_oe watchdog", oe, 1'h1);
    chk("reset_pin_out watchdog", rpo, 1'h0);
    chk("system_reset watchdog", sysr, 1'h1);
    wait_done();
    chk("reset_internal watchdog", rint, 1'h1);
    chk("irq_edge_mode after reset", iem, 1'h0);
    chk("nmi_masked after reset", nmsk, 1'h1);
    pulse(cm);
    chk("reset_pin_oe clock monitor", oe, 1'h1);
    wait_done();
    chk("reset_internal clock monitor", rint, 1'h1);
    ext = 1'h1;
    cyc(2);
    chk("system_reset synchronising", sysr, 1'h0);
    cyc(3);
    chk("system_reset external", sysr, 1'h1);
    cyc(15);
    ext = 1'h0;
    wait_done();
    chk("reset_internal external", rint, 1'h0);
    $display("test reset pin done");
    test_done();
  end
endmodule // rcip_pin_logic_tb_top
